//--- design/fwr_cmd_dec.sv
// Wrap setup, software reset, deep sleep and ID readout command decoder
`timescale 1ns/1ps
`default_nettype none
`include "fwr_map.svh"
module fwr_cmd_dec #(
  parameter logic [7:0] MAKER_ID = 8'h5A,  // Arbitrary value
  parameter logic [7:0] DEVICE_ID = 8'hA5, // Arbitrary value
  parameter int T_RST_NS = `FWR_T_RST_NS
) (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RESET,
  // Serial link pins
  input wire logic SPI_CS_N,
  input wire logic SPI_SCK,
  input wire logic SPI_DI,
  output logic SPI_DO,
  output logic SPI_DO_OE,
  // State from the rest of the device
  input wire logic BUSY,
  input wire logic QUAD_ENABLE_BIT,
  input wire logic [1:0] CONT_READ_SELECT_BITS,
  input wire logic PARAM_WRAP_STB,
  input wire logic [1:0] PARAM_WRAP_LEN,
  // Settings and status toward the rest of the device
  output fwr_pkg::fwr_wrap_t WRAP_SETTING_BITS,
  output logic [5:0] WRAP_SECTION_MASK,
  output logic SOFT_RESET,
  output logic DEEP_SLEEP,
  output logic CMD_READY
);
  localparam int DP_I = (`FWR_T_DP_NS * 1000) / `FWR_CLK_PS;
  localparam int RES1_I = (`FWR_T_RES1_NS * 1000 + `FWR_CLK_PS - 1)
                          / `FWR_CLK_PS;
  localparam int RES2_I = (`FWR_T_RES2_NS * 1000 + `FWR_CLK_PS - 1)
                          / `FWR_CLK_PS;
  localparam int RCH_I = (`FWR_T_RCH_NS * 1000 + `FWR_CLK_PS - 1)
                         / `FWR_CLK_PS;
  localparam int RST_I = (T_RST_NS * 1000 + `FWR_CLK_PS - 1) / `FWR_CLK_PS;
  localparam logic [15:0] DP_CYC = 16'((DP_I < 1) ? 1 : DP_I);
  localparam logic [15:0] RES1_CYC = 16'(RES1_I);
  localparam logic [15:0] RES2_CYC = 16'(RES2_I);
  localparam logic [15:0] RCH_CYC = 16'(RCH_I);
  localparam logic [15:0] RST_CYC = 16'(RST_I);

  // Pin synchronisers; stage 1 feeds only stage 2
  logic [2:0] cs_q, sck_q;
  logic [1:0] di_q;
  logic cs_s, sck_s, di_s, sck_rise, sck_fall, cs_fall, cs_rise;

  // Decoder state
  fwr_pkg::fwr_state_t st_q, st_d;
  logic [5:0] bits_q, bits_d;
  logic [31:0] sh_q, sh_d;
  logic [7:0] opc_q, opc_d, sh_byte;
  logic [3:0] idx_q, idx_d;
  logic [15:0] stream_q, stream_d;
  logic do_q, do_d;
  fwr_pkg::fwr_wrap_t wrap_q, wrap_d;
  logic rst_en_q, rst_en_d, srst_q, srst_d;
  logic slp_q, slp_d, pend_q, pend_d, rel_q, rel_d;
  logic [15:0] tmr_q, tmr_d, rcv_q, rcv_d, since_q, since_d;
  logic asleep, ready, quiet;

  assign cs_s = cs_q[1];
  assign sck_s = sck_q[1];
  assign di_s = di_q[1];
  assign sck_rise = sck_s & ~sck_q[2];
  assign sck_fall = ~sck_s & sck_q[2];
  assign cs_fall = ~cs_s & cs_q[2];
  assign cs_rise = cs_s & ~cs_q[2];
  assign sh_byte = {sh_q[6:0], di_s};
  assign asleep = slp_q | pend_q;
  // While a delay runs, new frames are dropped whole, not queued
  assign ready = ~pend_q & ~rel_q & (rcv_q == 16'h0000);
  // Continuous read owns the frame, so nothing here decodes it
  assign quiet = (CONT_READ_SELECT_BITS == `FWR_CONT_ACTIVE);

  always_comb begin
    st_d = st_q;
    bits_d = bits_q;
    sh_d = sh_q;
    opc_d = opc_q;
    idx_d = idx_q;
    stream_d = stream_q;
    do_d = do_q;
    wrap_d = wrap_q;
    rst_en_d = rst_en_q;
    srst_d = 1'b0;
    slp_d = slp_q;
    pend_d = pend_q;
    rel_d = rel_q;
    tmr_d = tmr_q;
    rcv_d = rcv_q;
    since_d = (since_q == 16'hFFFF) ? since_q : since_q + 16'h0001;
    if (PARAM_WRAP_STB) begin
      wrap_d.len = PARAM_WRAP_LEN;
    end
    if (tmr_q != 16'h0000) begin
      tmr_d = tmr_q - 16'h0001;
    end else if (pend_q) begin
      pend_d = 1'b0;
      slp_d = 1'b1;
    end else if (rel_q) begin
      rel_d = 1'b0;
      slp_d = 1'b0;
    end
    if (rcv_q != 16'h0000) begin
      rcv_d = rcv_q - 16'h0001;
    end
    if (cs_fall) begin
      // Not ready or continuous read: whole frame is ignored
      st_d = (ready && !quiet) ? fwr_pkg::FWR_OPC
                               : fwr_pkg::FWR_IGNORE;
      bits_d = 6'h00;
      sh_d = 32'h0000_0000;
      opc_d = `FWR_OP_NONE;
      idx_d = 4'h0;
    end else if (cs_rise) begin
      st_d = fwr_pkg::FWR_IDLE;
      if (bits_q == `FWR_BITS_OPC_DONE && !asleep) begin
        if (opc_q == `FWR_OP_SLEEP) begin
          pend_d = 1'b1;
          tmr_d = DP_CYC;
        end else if (opc_q == `FWR_OP_RST_EN) begin
          rst_en_d = 1'b1;
        end else if (opc_q == `FWR_OP_RST) begin
          rst_en_d = 1'b0;
          // Reset executes only after the hold time since the last bit
          if (rst_en_q && since_q >= RCH_CYC) begin
            srst_d = 1'b1;
            wrap_d.dis = `FWR_WRAP_DIS_RST;
            wrap_d.len = `FWR_WRAP_LEN_RST;
            rcv_d = RST_CYC;
          end
        end
      end
      // Release needs the full opcode; the longer delay once 32 bits were clocked
      if (slp_q && !pend_q && opc_q == `FWR_OP_RELEASE &&
          bits_q >= `FWR_BITS_OPC_DONE) begin
        rel_d = 1'b1;
        tmr_d = (bits_q >= `FWR_BITS_ID_READ) ? RES2_CYC : RES1_CYC;
      end
    end else if (!cs_s && sck_rise && st_q != fwr_pkg::FWR_IDLE) begin
      sh_d = {sh_q[30:0], di_s};
      since_d = 16'h0000;
      if (bits_q != `FWR_BITS_MAX) begin
        bits_d = bits_q + 6'h01;
      end
      case (st_q)
        fwr_pkg::FWR_OPC: begin
          if (bits_q == `FWR_BITS_OPC) begin
            opc_d = sh_byte;
            if (sh_byte != `FWR_OP_RST) begin
              rst_en_d = 1'b0;
            end
            if (asleep) begin
              // A busy device refuses release too, so sleep is kept
              if (sh_byte == `FWR_OP_RELEASE && !BUSY) begin
                st_d = fwr_pkg::FWR_ADDR;
              end else begin
                st_d = fwr_pkg::FWR_IGNORE;
                opc_d = `FWR_OP_NONE;
              end
            end else if (sh_byte == `FWR_OP_RELEASE) begin
              st_d = BUSY ? fwr_pkg::FWR_IGNORE
                          : fwr_pkg::FWR_ADDR;
            end else if (sh_byte == `FWR_OP_MFR_ID ||
                         (sh_byte == `FWR_OP_WRAP && QUAD_ENABLE_BIT)) begin
              st_d = fwr_pkg::FWR_ADDR;
            end else begin
              st_d = fwr_pkg::FWR_IGNORE;
            end
          end
        end
        fwr_pkg::FWR_ADDR: begin
          if (bits_q == `FWR_BITS_ADDR_END) begin
            if (opc_q == `FWR_OP_WRAP) begin
              st_d = fwr_pkg::FWR_WRAPB;
            end else begin
              st_d = fwr_pkg::FWR_OUT;
              if (opc_q == `FWR_OP_RELEASE) begin
                stream_d = {DEVICE_ID, DEVICE_ID};
              end else if (sh_byte[0]) begin
                stream_d = {DEVICE_ID, MAKER_ID};
              end else begin
                stream_d = {MAKER_ID, DEVICE_ID};
              end
            end
          end
        end
        fwr_pkg::FWR_WRAPB: begin
          if (bits_q == `FWR_BITS_WRAP_END) begin
            // Top bit and low nibble of the wrap byte are dropped
            wrap_d.dis = sh_byte[`FWR_WB_DIS];
            wrap_d.len = sh_byte[`FWR_WB_LEN_HI:`FWR_WB_LEN_LO];
            st_d = fwr_pkg::FWR_IGNORE;
          end
        end
        fwr_pkg::FWR_OUT: begin
          st_d = fwr_pkg::FWR_OUT;
        end
        fwr_pkg::FWR_IGNORE: begin
          st_d = fwr_pkg::FWR_IGNORE;
        end
        default: begin
          st_d = fwr_pkg::FWR_IGNORE;
        end
      endcase
    end else if (!cs_s && sck_fall && st_q == fwr_pkg::FWR_OUT) begin
      // Index wraps at 16, so the ID pair repeats until select rises
      do_d = stream_q[4'hF - idx_q];
      idx_d = idx_q + 4'h1;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    cs_q <= {cs_q[1:0], SPI_CS_N};
    sck_q <= {sck_q[1:0], SPI_SCK};
    di_q <= {di_q[0], SPI_DI};
    if (RESET) begin
      st_q <= fwr_pkg::FWR_IDLE;
      bits_q <= 6'h00;
      sh_q <= 32'h0000_0000;
      opc_q <= `FWR_OP_NONE;
      idx_q <= 4'h0;
      stream_q <= 16'h0000;
      do_q <= 1'b0;
      wrap_q.dis <= `FWR_WRAP_DIS_RST;
      wrap_q.len <= `FWR_WRAP_LEN_RST;
      rst_en_q <= 1'b0;
      srst_q <= 1'b0;
      slp_q <= 1'b0;
      pend_q <= 1'b0;
      rel_q <= 1'b0;
      tmr_q <= 16'h0000;
      rcv_q <= 16'h0000;
      since_q <= 16'h0000;
    end else begin
      st_q <= st_d;
      bits_q <= bits_d;
      sh_q <= sh_d;
      opc_q <= opc_d;
      idx_q <= idx_d;
      stream_q <= stream_d;
      do_q <= do_d;
      wrap_q <= wrap_d;
      rst_en_q <= rst_en_d;
      srst_q <= srst_d;
      slp_q <= slp_d;
      pend_q <= pend_d;
      rel_q <= rel_d;
      tmr_q <= tmr_d;
      rcv_q <= rcv_d;
      since_q <= since_d;
    end
  end

  always_comb begin
    case ({wrap_q.dis, wrap_q.len})
      3'b000: WRAP_SECTION_MASK = `FWR_MASK_8;
      3'b001: WRAP_SECTION_MASK = `FWR_MASK_16;
      3'b010: WRAP_SECTION_MASK = `FWR_MASK_32;
      3'b011: WRAP_SECTION_MASK = `FWR_MASK_64;
      default: WRAP_SECTION_MASK = 6'h00;
    endcase
  end

  assign WRAP_SETTING_BITS = wrap_q;
  assign SPI_DO = do_q;
  assign SPI_DO_OE = (st_q == fwr_pkg::FWR_OUT) & ~cs_s;
  assign SOFT_RESET = srst_q;
  assign DEEP_SLEEP = slp_q;
  assign CMD_READY = ready;
endmodule
`default_nettype wire

//--- design/fwr_map.svh
// Opcodes, bit counts, defaults and timing figures of the command decoder
`ifndef FWR_MAP_SVH
`define FWR_MAP_SVH
`define FWR_OP_NONE 8'h00
`define FWR_OP_WRAP 8'h77
`define FWR_OP_RST_EN 8'h66
`define FWR_OP_RST 8'h99
`define FWR_OP_SLEEP 8'hB9
`define FWR_OP_RELEASE 8'hAB
`define FWR_OP_MFR_ID 8'h90
`define FWR_CONT_ACTIVE 2'h2
`define FWR_BITS_OPC 6'h07
`define FWR_BITS_OPC_DONE 6'h08
`define FWR_BITS_ADDR_END 6'h1F
`define FWR_BITS_ID_READ 6'h20
`define FWR_BITS_WRAP_END 6'h27
`define FWR_BITS_MAX 6'h3F
`define FWR_WB_DIS 4
`define FWR_WB_LEN_HI 6
`define FWR_WB_LEN_LO 5
`define FWR_WRAP_DIS_RST 1'h1
`define FWR_WRAP_LEN_RST 2'h0
`define FWR_MASK_8 6'h07
`define FWR_MASK_16 6'h0F
`define FWR_MASK_32 6'h1F
`define FWR_MASK_64 6'h3F
`define FWR_CLK_PS 5000
`define FWR_T_DP_NS 3000
`define FWR_T_RES1_NS 3000
`define FWR_T_RES2_NS 5000
`define FWR_T_RCH_NS 50
`define FWR_T_RST_NS 30000
`endif

//--- design/fwr_pkg.sv
// Types shared by the wrap, reset, power-down and ID command decoder
package fwr_pkg;
  typedef struct packed {
    logic dis;
    logic [1:0] len;
  } fwr_wrap_t;

  typedef enum logic [2:0] {
    FWR_IDLE = 3'b000,
    FWR_OPC = 3'b001,
    FWR_ADDR = 3'b010,
    FWR_WRAPB = 3'b011,
    FWR_OUT = 3'b100,
    FWR_IGNORE = 3'b101
  } fwr_state_t;
endpackage

//--- tb/fwr_cmd_dec_sva.sv
// Concurrent checks on the command decoder ports
`timescale 1ns/1ps
`default_nettype none
module fwr_cmd_dec_sva (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RESET,
  // Inputs watched
  input wire logic PARAM_WRAP_STB,
  input wire logic [1:0] PARAM_WRAP_LEN,
  // Outputs watched
  input wire fwr_pkg::fwr_wrap_t WRAP_SETTING_BITS,
  input wire logic [5:0] WRAP_SECTION_MASK,
  input wire logic SOFT_RESET,
  input wire logic DEEP_SLEEP,
  input wire logic CMD_READY
);
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (RESET);

  mask_map_a: assert property (
    WRAP_SECTION_MASK == (WRAP_SETTING_BITS.dis ? 6'h00 :
    6'((7'h08 << WRAP_SETTING_BITS.len) - 7'h01)))
    else $error("wrap mask mismatch");
  pulse_once_a: assert property (SOFT_RESET |=> !SOFT_RESET)
    else $error("reset pulse too long");
  reset_wrap_a: assert property (SOFT_RESET |-> ##[0:1]
    WRAP_SETTING_BITS == 3'b100) else $error("wrap not restored");
  reset_busy_a: assert property (SOFT_RESET |-> ##[0:1] !CMD_READY)
    else $error("no recovery after reset");
  sleep_reset_a: assert property (DEEP_SLEEP |-> !SOFT_RESET)
    else $error("reset taken in sleep");
  sleep_entry_a: assert property (
    $rose(DEEP_SLEEP) |-> !$past(CMD_READY))
    else $error("sleep without entry delay");
  sleep_hold_a: assert property (
    DEEP_SLEEP && !PARAM_WRAP_STB |=> $stable(WRAP_SETTING_BITS))
    else $error("wrap changed in sleep");
  param_load_a: assert property (
    PARAM_WRAP_STB |=> WRAP_SETTING_BITS.len == $past(PARAM_WRAP_LEN))
    else $error("wrap length not loaded");

  cover property (SOFT_RESET);
  cover property ($rose(DEEP_SLEEP));
  cover property (PARAM_WRAP_STB);
endmodule
`default_nettype wire

//--- tb/fwr_cmd_dec_tb_top.sv
// Self-checking bench for the wrap, reset, sleep and ID decoder
`timescale 1ns/1ps
`default_nettype none
module fwr_cmd_dec_tb_top;
  localparam logic [7:0] MAKER = 8'h5A; // Arbitrary value
  localparam logic [7:0] DEV = 8'hA5; // Arbitrary value
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic busy = 1'b0;
  logic qe = 1'b1;
  logic stb = 1'b0;
  logic [1:0] crs = 2'h0;
  logic [1:0] plen = 2'h0;
  logic m_dis = 1'b1;
  logic [1:0] m_len = 2'h0;
  logic [7:0] lfsr = 8'h33;
  logic [15:0] rx;
  int num_errors = 0;
  int compares = 0;
  int cyc = 0;
  int n_rst = 0;
  int exp_rst = 0;
  logic [7:0] id_q[$];
  wire logic cs_n, sck, di, dout, oe, srst, sleep, rdy;
  wire fwr_pkg::fwr_wrap_t wrap;
  wire logic [5:0] mask;

  always #2.5 clk = ~clk;

  fwr_cmd_dec #(.MAKER_ID(MAKER), .DEVICE_ID(DEV), .T_RST_NS(100)) dut (
    .SYS_CLK(clk), .RESET(rst), .SPI_CS_N(cs_n), .SPI_SCK(sck),
    .SPI_DI(di), .SPI_DO(dout), .SPI_DO_OE(oe), .BUSY(busy),
    .QUAD_ENABLE_BIT(qe), .CONT_READ_SELECT_BITS(crs),
    .PARAM_WRAP_STB(stb), .PARAM_WRAP_LEN(plen),
    .WRAP_SETTING_BITS(wrap), .WRAP_SECTION_MASK(mask),
    .SOFT_RESET(srst), .DEEP_SLEEP(sleep), .CMD_READY(rdy));
  fwr_host host (.clk(clk), .cs_n(cs_n), .sck(sck), .di(di), .dout(dout),
    .oe(oe));

  function automatic logic [7:0] nxt(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  task automatic complete_run();
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] exp, got);
    compares++;
    if (exp !== got) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic send(input logic [39:0] tx, input int n);
    host.xfer(tx, n, rx);
  endtask

  task automatic chk_wrap();
    check("wrap", {13'h0, m_dis, m_len}, 16'(wrap));
    check("mask", m_dis ? 16'h0 : 16'((8 << m_len) - 1), 16'(mask));
  endtask

  // Expected ID bytes queue up in rule order and leave in pairs
  task automatic chk_id(input string what, input logic [7:0] b0, b1);
    logic [15:0] want;
    id_q.push_back(b0);
    id_q.push_back(b1);
    want[15:8] = id_q.pop_front();
    want[7:0] = id_q.pop_front();
    check(what, want, rx);
  endtask

  task automatic sleep_step(input logic [7:0] op, input int n,
                            input logic r, e);
    send({op, 32'h0}, n);
    check("ready", {15'h0, r}, {15'h0, rdy});
    repeat (700) @(posedge clk);
    check("sleep", {15'h0, e}, {15'h0, sleep});
  endtask

  always @(posedge clk) begin
    cyc++;
    if (srst === 1'b1)
      n_rst++;
    if (cyc == 60000) begin
      num_errors++;
      complete_run();
    end
  end

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (5) @(posedge clk);
    chk_wrap();
    check("sleep", 16'h0, {15'h0, sleep});
    for (int i = 0; i < 5; i++) begin
      lfsr = nxt(lfsr);
      m_dis = (i == 4);
      m_len = (i < 4) ? 2'(i) : lfsr[6:5];
      send({8'h77, 24'h0, lfsr[7], m_len, m_dis, lfsr[3:0]}, 40);
      chk_wrap();
    end
    qe <= 1'b0;
    send({8'h77, 24'h0, 8'h60}, 40);
    chk_wrap();
    qe <= 1'b1;
    lfsr = nxt(lfsr);
    plen <= lfsr[1:0];
    stb <= 1'b1;
    @(posedge clk);
    stb <= 1'b0;
    m_len = lfsr[1:0];
    @(posedge clk);
    chk_wrap();
    $display("wrap tests done");
    send({8'h77, 24'h0, 8'h40}, 40);
    m_dis = 1'b0;
    m_len = 2'h2;
    send({8'h90, 32'h0}, 48);
    chk_id("id0", MAKER, DEV);
    send({8'h90, 24'h1, 8'h0}, 48);
    chk_id("id1", DEV, MAKER);
    send({8'hAB, 32'h0}, 48);
    chk_id("devid", DEV, DEV);
    $display("id tests done");
    crs <= 2'h2;
    send({8'h66, 32'h0}, 8);
    send({8'h99, 32'h0}, 8);
    crs <= 2'h0;
    check("cont", 16'(exp_rst), 16'(n_rst));
    send({8'h66, 32'h0}, 8);
    send({8'h77, 24'h0, 8'h40}, 40);
    send({8'h99, 32'h0}, 8);
    check("cleared", 16'(exp_rst), 16'(n_rst));
    send({8'h66, 32'h0}, 8);
    send({8'h99, 32'h0}, 8);
    exp_rst++;
    m_dis = 1'b1;
    m_len = 2'h0;
    check("reset", 16'(exp_rst), 16'(n_rst));
    chk_wrap();
    // The wrap write lost to the reset is issued again
    send({8'h77, 24'h0, 8'h40}, 40);
    m_dis = 1'b0;
    m_len = 2'h2;
    chk_wrap();
    $display("reset tests done");
    sleep_step(8'hB9, 9, 1'b1, 1'b0);
    sleep_step(8'hB9, 8, 1'b0, 1'b1);
    send({8'h66, 32'h0}, 8);
    send({8'h99, 32'h0}, 8);
    check("sleep reset", 16'(exp_rst), 16'(n_rst));
    send({8'h77, 24'h0, 8'h60}, 40);
    chk_wrap();
    busy <= 1'b1;
    sleep_step(8'hAB, 8, 1'b1, 1'b1);
    busy <= 1'b0;
    sleep_step(8'hAB, 8, 1'b0, 1'b0);
    sleep_step(8'hB9, 8, 1'b0, 1'b1);
    sleep_step(8'hAB, 48, 1'b0, 1'b1);
    chk_id("wake id", DEV, DEV);
    repeat (300) @(posedge clk);
    check("woken", 16'h0, {15'h0, sleep});
    check("ready", 16'h1, {15'h0, rdy});
    $display("sleep tests done");
    complete_run();
  end
endmodule

bind fwr_cmd_dec fwr_cmd_dec_sva chk (
  .SYS_CLK(SYS_CLK), .RESET(RESET), .PARAM_WRAP_STB(PARAM_WRAP_STB),
  .PARAM_WRAP_LEN(PARAM_WRAP_LEN), .WRAP_SETTING_BITS(WRAP_SETTING_BITS),
  .WRAP_SECTION_MASK(WRAP_SECTION_MASK), .SOFT_RESET(SOFT_RESET),
  .DEEP_SLEEP(DEEP_SLEEP), .CMD_READY(CMD_READY));
`default_nettype wire

//--- tb/fwr_host.sv
// Host serial controller model: select, clock and data toward the decoder
`timescale 1ns/1ps
`default_nettype none
module fwr_host (
  // Clock
  input wire logic clk,
  // Serial pins
  output logic cs_n,
  output logic sck,
  output logic di,
  input wire logic dout,
  input wire logic oe
);
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    di = 1'b0;
  end

  // Mode 0 frame; the clock rests low between frames
  task automatic xfer(input logic [39:0] tx, input int n,
                      output logic [15:0] rx);
    rx = 16'h0000;
    @(posedge clk);
    cs_n <= 1'b0;
    for (int i = 0; i < n; i++) begin
      di <= (i < 40) ? tx[39 - i] : 1'b0;
      repeat (13) @(posedge clk);
      sck <= 1'b1;
      // An undriven line reads as the inverse, so a late enable shows
      rx = {rx[14:0], oe ? dout : ~dout};
      repeat (12) @(posedge clk);
      sck <= 1'b0;
    end
    // Long hold before select rises so a reset always meets the hold time
    repeat (13) @(posedge clk);
    cs_n <= 1'b1;
    di <= ~di;
    repeat (40) @(posedge clk);
  endtask
endmodule
`default_nettype wire
